//--- hw/qrbsp_bank.v
// Purpose: One bank of the array, one word of each burst
// Assumes: Single clock, write and read in the same cycle allowed
// Notes: Write-first on address match so reads see the newest data
`timescale 1ns/1ps
`default_nettype none
`include "qrbsp_defs.vh"
module qrbsp_bank
#(
   parameter AW = `QRBSP_AW,
   parameter DW = `QRBSP_DW,
   parameter LW = `QRBSP_LW,
   parameter NL = `QRBSP_NL
)
(
   // Clock and reset
   input  wire          clk,
   input  wire          rst_n,
   // Write side
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire [NL-1:0] wbe_n,
   // Read side
   input  wire          re,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata
);

   reg [DW-1:0] mem [0:(1<<AW)-1];
   reg [DW-1:0] merged;
   integer      i;

   // Unselected lanes keep the stored value
   always @*
   begin
      merged = mem[waddr];
      for (i = 0; i < NL; i = i + 1)
         if (!wbe_n[i])
            merged[i*LW +: LW] = wdata[i*LW +: LW];
   end

   always @(posedge clk)
   begin
      if (we)
         mem[waddr] <= merged;
   end

   // Bypass keeps a same-cycle write visible to the read
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= {DW{1'b0}};
      else if (re)
         rdata <= (we && (waddr == raddr)) ? merged : mem[raddr];
   end

endmodule
`default_nettype wire

//--- hw/qrbsp_defs.vh
// Purpose: Shared constants of the burst SRAM port
// Assumes: Included by bare name from the bank and port design files
// Notes: Definitions only
`ifndef QRBSP_DEFS_VH
`define QRBSP_DEFS_VH

// Array geometry
`define QRBSP_AW          19
`define QRBSP_DW          36
`define QRBSP_LW          9
`define QRBSP_NL          4
`define QRBSP_BURST_LAST  2'h3

// APB register map
`define QRBSP_CTRL_OFF    12'h000
`define QRBSP_STAT_OFF    12'h004
`define QRBSP_CTRL_RST    1'b1
`define QRBSP_EN_BIT      0
`define QRBSP_ST_RBUSY    0
`define QRBSP_ST_WBUSY    1
`define QRBSP_ST_LATLONG  2
`define QRBSP_ST_PHASE    3

// Fetch point in edges counted after capture; read data launch at this count plus two half-periods
`define QRBSP_FETCH_LONG  3'h3
`define QRBSP_FETCH_SHORT 3'h0

`endif

//--- hw/qrbsp_port.v
// Purpose: Separate-port burst SRAM with double data rate on both ports
// Assumes: Link clocks are slow against pclk; pins stable around link edges
// Notes: Link edges are found by sampling the two link clocks with pclk
// Contract
// - Read data leave on an output bus, write data enter on a separate bus.
// - Read and write addresses captured on alternating link clock rising edges.
// - Each address holds four consecutive 36-bit words moved as one burst.
// - Burst words move on every rising edge of both link clocks.
// - Latency pin high: read data start 2.5 cycles after address capture.
// - Latency pin low: read data start one cycle after address capture.
// - Read and write bursts run independently and may overlap.
// - Each port has its own active-low select for depth expansion.
// - Synchronous inputs are registered on link clock rising edges.
// - Read data come from output registers updated on link clock edges.
// - Array writes are self-timed; controller gives only address, data, lanes.
// - Complementary echo clocks are driven alongside read data.
// - Valid flag marks the phases carrying valid read data.
// - Reads return the newest written data, including writes in progress.
// - Only rising edges of the two link clocks launch or capture.
// - Read select low starts four-word read; deselect floats outputs after edge.
// - Write select low starts a write; write data ignored while deselected.
// - Four active-low lane selects choose written bytes on every edge.
// - Four banks of 512K words, 19 address bits, ignored when deselected.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "qrbsp_defs.vh"
module qrbsp_port
(
   // APB slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Link clocks
   input  wire        link_k,
   input  wire        link_k_n,
   // Address and selects
   input  wire [18:0] addr_in,
   input  wire        read_port_select_n,
   input  wire        write_port_select_n,
   input  wire        latency_mode_pin,
   // Write port
   input  wire [35:0] wr_data,
   input  wire [3:0]  byte_lane_select_n,
   // Read port
   output wire [35:0] rd_data,
   output wire        rd_data_oe_n,
   output wire        read_valid_flag,
   output wire        echo_strobe,
   output wire        echo_strobe_n
);

   // Synchronised pins
   wire [1:0]   clk_s;
   wire [61:0]  pin_s;
   wire [18:0]  addr_s;
   wire         rps_n_s;
   wire         wps_n_s;
   wire [35:0]  wd_s;
   wire [3:0]   lane_n_s;
   wire         lat_long_s;

   // Edge detection
   reg          k_d_q;
   reg          kn_d_q;
   reg          kn_arm_q;
   wire         k_rise;
   wire         kn_rise;
   wire         any_edge;

   // Slot phase and control
   reg          ph_q;
   reg          ctrl_en_q;
   wire         rd_start;
   wire         wr_start;

   // Write burst state
   reg          wact_q;
   reg  [1:0]   wcnt_q;
   reg  [18:0]  waddr_q;

   // Read burst state
   reg          hold_v_q;
   reg  [2:0]   hold_cnt_q;
   reg  [18:0]  hold_addr_q;
   reg          act_v_q;
   reg  [1:0]   fcnt_q;
   reg  [18:0]  act_addr_q;
   reg          pend_v_q;
   reg  [1:0]   pend_w_q;
   wire         fetch_go;
   wire         rd_fetch;
   wire [18:0]  rd_addr;
   wire [143:0] bank_rd;

   // Output registers
   reg  [35:0]  q_q;
   reg          oe_n_q;
   reg          vld_q;
   reg          echo_q;
   reg          echo_n_q;

   // APB
   reg  [31:0]  prdata_q;
   reg          pslverr_q;
   wire         apb_setup;
   wire         apb_wr;
   wire         hit_ctrl;
   wire         hit_stat;
   wire [3:0]   status;

   qrbsp_sync #(.W(2)) u_clk_sync
   (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({link_k_n, link_k}),
      .q     (clk_s)
   );

   qrbsp_sync #(.W(62)) u_pin_sync
   (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({latency_mode_pin, byte_lane_select_n, wr_data,
               write_port_select_n, read_port_select_n, addr_in}),
      .q     (pin_s)
   );

   assign addr_s     = pin_s[18:0];
   assign rps_n_s    = pin_s[19];
   assign wps_n_s    = pin_s[20];
   assign wd_s       = pin_s[56:21];
   assign lane_n_s   = pin_s[60:57];
   assign lat_long_s = pin_s[61];

   // Falling edges are used only to arm the complement rise detector
   assign k_rise   = clk_s[0] & ~k_d_q;
   assign kn_rise  = clk_s[1] & ~kn_d_q & kn_arm_q;
   assign any_edge = k_rise | kn_rise;

   // Even slot reads, odd slot writes; deselect ignores address
   assign rd_start = k_rise & ~ph_q & ~rps_n_s & ctrl_en_q;
   assign wr_start = k_rise & ph_q & ~wps_n_s & ctrl_en_q;

   // Long mode fetches one edge before the 2.5-cycle launch point
   assign fetch_go = hold_v_q & (hold_cnt_q == (lat_long_s ? `QRBSP_FETCH_LONG
                                                           : `QRBSP_FETCH_SHORT));
   assign rd_fetch = any_edge & (fetch_go | act_v_q);
   assign rd_addr  = fetch_go ? hold_addr_q : act_addr_q;

   // Bank n holds word n of every burst
   genvar gi;
   generate
      for (gi = 0; gi < `QRBSP_NL; gi = gi + 1)
      begin : g_bank
         qrbsp_bank u_bank
         (
            .clk   (pclk),
            .rst_n (presetn),
            .we    (any_edge & wact_q & (wcnt_q == gi)),
            .waddr (waddr_q),
            .wdata (wd_s),
            .wbe_n (lane_n_s),
            .re    (rd_fetch),
            .raddr (rd_addr),
            .rdata (bank_rd[gi*36 +: 36])
         );
      end
   endgenerate

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         k_d_q    <= 1'b0;
         kn_d_q   <= 1'b0;
         kn_arm_q <= 1'b0;
         echo_q   <= 1'b0;
         echo_n_q <= 1'b0;
      end
      else
      begin
         k_d_q    <= clk_s[0];
         kn_d_q   <= clk_s[1];
         echo_q   <= clk_s[0];
         echo_n_q <= clk_s[1];
         // Complement idles high; the flops' rise after reset is no real edge
         if (kn_d_q & ~clk_s[1])
            kn_arm_q <= 1'b1;
      end
   end

   // Write port; data taken only during an active burst
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ph_q    <= 1'b0;
         wact_q  <= 1'b0;
         wcnt_q  <= 2'h0;
         waddr_q <= 19'h00000;
      end
      else
      begin
         if (k_rise)
            ph_q <= ~ph_q;
         if (any_edge)
         begin
            if (wact_q)
            begin
               wcnt_q <= wcnt_q + 2'h1;
               if (wcnt_q == `QRBSP_BURST_LAST)
                  wact_q <= 1'b0;
            end
            if (wr_start)
            begin
               wact_q  <= 1'b1;
               waddr_q <= addr_s;
               wcnt_q  <= 2'h0;
            end
         end
      end
   end

   // Read port; runs beside the write burst without interlock
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_v_q    <= 1'b0;
         hold_cnt_q  <= 3'h0;
         hold_addr_q <= 19'h00000;
         act_v_q     <= 1'b0;
         fcnt_q      <= 2'h0;
         act_addr_q  <= 19'h00000;
         pend_v_q    <= 1'b0;
         pend_w_q    <= 2'h0;
         q_q         <= 36'h000000000;
         oe_n_q      <= 1'b1;
         vld_q       <= 1'b0;
      end
      else if (any_edge)
      begin
         if (hold_v_q)
            hold_cnt_q <= hold_cnt_q + 3'h1;
         pend_v_q <= 1'b0;
         if (act_v_q)
         begin
            pend_v_q <= 1'b1;
            pend_w_q <= fcnt_q;
            fcnt_q   <= fcnt_q + 2'h1;
            if (fcnt_q == `QRBSP_BURST_LAST)
               act_v_q <= 1'b0;
         end
         if (fetch_go)
         begin
            hold_v_q   <= 1'b0;
            act_v_q    <= 1'b1;
            act_addr_q <= hold_addr_q;
            fcnt_q     <= 2'h1;
            pend_v_q   <= 1'b1;
            pend_w_q   <= 2'h0;
         end
         // A new capture may coincide with the previous fetch start
         if (rd_start)
         begin
            hold_v_q    <= 1'b1;
            hold_addr_q <= addr_s;
            hold_cnt_q  <= 3'h0;
         end
         // Launch; outputs float from the edge after the last word
         vld_q  <= pend_v_q;
         oe_n_q <= ~pend_v_q;
         if (pend_v_q)
            q_q <= bank_rd[pend_w_q*36 +: 36];
      end
   end

   assign rd_data         = q_q;
   assign rd_data_oe_n    = oe_n_q;
   assign read_valid_flag = vld_q;
   assign echo_strobe     = echo_q;
   assign echo_strobe_n   = echo_n_q;

   // APB: zero wait states, read data latched in the setup cycle
   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pwrite;
   assign hit_ctrl  = (paddr == `QRBSP_CTRL_OFF);
   assign hit_stat  = (paddr == `QRBSP_STAT_OFF);

   assign status[`QRBSP_ST_RBUSY]   = hold_v_q | act_v_q | pend_v_q;
   assign status[`QRBSP_ST_WBUSY]   = wact_q;
   assign status[`QRBSP_ST_LATLONG] = lat_long_s;
   assign status[`QRBSP_ST_PHASE]   = ph_q;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_en_q <= `QRBSP_CTRL_RST;
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         if (apb_setup)
         begin
            pslverr_q <= ~(hit_ctrl | hit_stat);
            if (hit_ctrl)
               prdata_q <= {31'h00000000, ctrl_en_q};
            else if (hit_stat)
               prdata_q <= {28'h0000000, status};
            else
               prdata_q <= 32'h00000000;
         end
         // Disabling only blocks new captures; bursts in flight finish
         if (apb_wr && hit_ctrl)
            ctrl_en_q <= pwdata[`QRBSP_EN_BIT];
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = pslverr_q;

endmodule
`default_nettype wire

//--- hw/qrbsp_sync.v
// Purpose: Two-flop synchroniser for pins arriving from outside pclk
// Assumes: Bits of a bus are stable around the sampled link clock edge
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module qrbsp_sync
#(
   parameter W = 1
)
(
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Data
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);

   reg [W-1:0] meta_q;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= {W{1'b0}};
         q      <= {W{1'b0}};
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule
`default_nettype wire

//--- tb/qrbsp_ctrl_model.sv
// Purpose: Memory controller model on the link side
// Assumes: Link clock runs free after reset
// Notes: Pins move 3 pclk after a link edge
`timescale 1ns/1ps
`default_nettype none
module qrbsp_ctrl_model
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Link pins
   output var  logic        link_k,
   output var  logic        link_k_n,
   output var  logic [18:0] addr_in,
   output var  logic        read_port_select_n,
   output var  logic        write_port_select_n,
   output var  logic [35:0] wr_data,
   output var  logic [3:0]  byte_lane_select_n,
   input  wire logic [35:0] rd_data,
   input  wire logic        rd_data_oe_n,
   input  wire logic        read_valid_flag
);
   logic        slot_q;
   logic [35:0] last_q;
   logic [35:0] q_seen;
   // Floated bus must not show a stale word
   assign q_seen = rd_data_oe_n ? ~last_q : rd_data;
   always @(posedge pclk)
      if (!rd_data_oe_n)
         last_q <= rd_data;
   always @(posedge link_k or negedge presetn)
      if (!presetn)
         slot_q <= 1'b0;
      else
         slot_q <= ~slot_q;
   initial
   begin
      {link_k, link_k_n} = 2'h1;
      addr_in = 19'h00000;
      {read_port_select_n, write_port_select_n} = 2'h3;
      wr_data = 36'h000000000;
      byte_lane_select_n = 4'hF;
      @(posedge presetn);
      // Offset keeps link edges off pclk edges, so sampling is race free
      #102;
      forever
         #62.5 {link_k, link_k_n} = ~{link_k, link_k_n};
   end
   task automatic step;
      @(posedge link_k or posedge link_k_n);
      repeat (3) @(posedge pclk);
   endtask
   // Mid-cycle before a k rise of slot s
   task automatic align(input logic s);
      do
         step;
      while (link_k || slot_q != s);
   endtask
   task automatic wr(input logic [18:0] a, input logic [143:0] d,
                     input logic [15:0] ln, input logic sel);
      align(1'b1);
      addr_in <= a;
      write_port_select_n <= sel;
      for (int i = 0; i < 4; i++)
      begin
         step;
         if (i == 0)
            addr_in <= ~a;
         write_port_select_n <= 1'b1;
         wr_data <= d[36*i +: 36];
         byte_lane_select_n <= ln[4*i +: 4];
      end
      step;
      wr_data <= ~wr_data;
      byte_lane_select_n <= 4'hF;
   endtask
   task automatic rd(input logic [18:0] a, output logic [359:0] qs,
                     output logic [9:0] vs);
      qs = 360'h0;
      vs = 10'h000;
      align(1'b0);
      addr_in <= a;
      read_port_select_n <= 1'b0;
      step;
      addr_in <= ~a;
      read_port_select_n <= 1'b1;
      for (int i = 1; i < 10; i++)
      begin
         @(posedge link_k or posedge link_k_n);
         repeat (5) @(posedge pclk);
         qs[36*i +: 36] = q_seen;
         vs[i] = read_valid_flag;
      end
   endtask
endmodule
`default_nettype wire

//--- tb/qrbsp_port_properties.sv
// Purpose: Port checks of the burst SRAM port
// Assumes: Link half-period near 6.25 pclk
// Notes: Bound to qrbsp_port
`timescale 1ns/1ps
`default_nettype none
module qrbsp_port_props
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Link pins
   input wire logic        link_k,
   input wire logic        link_k_n,
   input wire logic        read_port_select_n,
   input wire logic        latency_mode_pin,
   input wire logic [35:0] rd_data,
   input wire logic        rd_data_oe_n,
   input wire logic        read_valid_flag,
   input wire logic        echo_strobe,
   input wire logic        echo_strobe_n
);
   logic [5:0] idle_q;
   logic [5:0] vcnt_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Saturating so long idle spans never wrap
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         idle_q <= 6'h3F;
      else
         idle_q <= read_port_select_n ? idle_q + {5'h00, ~&idle_q} : 6'h00;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         vcnt_q <= 6'h00;
      else
         vcnt_q <= read_valid_flag ? vcnt_q + {5'h00, ~&vcnt_q} : 6'h00;
   a_valid_drives: assert property (read_valid_flag |-> !rd_data_oe_n)
      else $error("valid word undriven");
   a_idle_floats: assert property (!read_valid_flag |-> rd_data_oe_n)
      else $error("bus driven when idle");
   a_four_words: assert property ($fell(read_valid_flag) |-> vcnt_q >= 6'h17)
      else $error("burst too short");
   a_word_hold: assert property ($changed(rd_data) && read_valid_flag
      |=> $stable(rd_data) [*4]) else $error("word too short");
   a_read_latency: assert property ($rose(read_valid_flag) && latency_mode_pin
      |-> idle_q inside {[6'h1C:6'h23]}) else $error("latency off");
   a_short_latency: assert property ($rose(read_valid_flag) && !latency_mode_pin
      |-> idle_q inside {[6'h09:6'h10]}) else $error("short latency off");
   a_deselect_quiet: assert property (idle_q > 6'h3D |-> !read_valid_flag)
      else $error("valid while idle");
   a_echo_true: assert property ($rose(link_k) |-> ##[1:5] $rose(echo_strobe))
      else $error("echo lost");
   a_echo_comp: assert property ($rose(link_k_n) |-> ##[1:5] $rose(echo_strobe_n))
      else $error("echo complement lost");
   c_burst: cover property ($fell(read_valid_flag));
   c_long: cover property ($rose(read_valid_flag) && idle_q > 6'h18);
   c_short: cover property ($rose(read_valid_flag) && idle_q < 6'h18);
endmodule
bind qrbsp_port qrbsp_port_props u_props (.pclk, .presetn, .link_k, .link_k_n,
   .read_port_select_n, .latency_mode_pin, .rd_data, .rd_data_oe_n, .read_valid_flag,
   .echo_strobe,
   .echo_strobe_n);
`default_nettype wire

//--- tb/tb_qrbsp_port.sv
// Purpose: Self-checking bench of the burst SRAM port
// Assumes: Controller model owns the link pins
// Notes: Reads checked per half-period
`timescale 1ns/1ps
`default_nettype none
module tb_qrbsp_port;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, r;
   logic         link_k, link_k_n, read_port_select_n, write_port_select_n;
   logic         latency_mode_pin, rd_data_oe_n, read_valid_flag;
   logic [18:0]  addr_in;
   logic [35:0]  wr_data, rd_data;
   logic [3:0]   byte_lane_select_n;
   logic [15:0]  ln;
   logic [143:0] d, x;
   int           n_mismatch, comparisons;
   qrbsp_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .link_k, .link_k_n, .addr_in, .read_port_select_n,
      .write_port_select_n, .latency_mode_pin, .wr_data, .byte_lane_select_n, .rd_data,
      .rd_data_oe_n, .read_valid_flag, .echo_strobe(), .echo_strobe_n());
   qrbsp_ctrl_model m (.pclk, .presetn, .link_k, .link_k_n, .addr_in, .read_port_select_n,
      .write_port_select_n, .wr_data, .byte_lane_select_n, .rd_data, .rd_data_oe_n,
      .read_valid_flag);
   initial
   begin
      pclk = 1'b0;
      forever
         #5 pclk = ~pclk;
   end
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'h0;
      // Idle edge so a following setup never re-drives psel in this step
      @(posedge pclk);
   endtask
   task automatic rd_chk(input logic [18:0] a, input int lat, input logic [143:0] w);
      logic [359:0] qs;
      logic [9:0]   vs;
      m.rd(a, qs, vs);
      for (int i = 1; i < 10; i++)
      begin
         chk(vs[i], i >= lat && i < lat + 4);
         if (i >= lat && i < lat + 4)
            chk(qs[36*i +: 36], w[36*(i-lat) +: 36]);
      end
   endtask
   initial
   begin
      #200000;
      n_mismatch++;
      finish_test;
   end
   initial
   begin
      {n_mismatch, comparisons} = 0;
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      latency_mode_pin = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      chk(r, 36'h1);
      apb(1'b0, 12'h004, 32'h0);
      chk(r[2:0], 36'h4);
      apb(1'b0, 12'h008, 32'h0);
      chk({e, r}, 36'h100000000);
      d = {36'h444444444, 36'h333333333, 36'h222222222, 36'h111111111};
      m.wr(19'h00005, d, 16'h0000, 1'b0);
      rd_chk(19'h00005, 5, d);
      x = d;
      d = ~d;
      ln = 16'h6DB6;
      for (int i = 0; i < 16; i++)
         if (!ln[i])
            x[9*i +: 9] = d[9*i +: 9];
      m.wr(19'h00005, d, ln, 1'b0);
      m.wr(19'h00005, ~x, 16'h0000, 1'b1);
      latency_mode_pin <= 1'b0;
      rd_chk(19'h00005, 2, x);
      apb(1'b1, 12'h000, 32'h0);
      rd_chk(19'h00005, 20, x);
      apb(1'b1, 12'h000, 32'h1);
      fork
         m.wr(19'h00007, d, 16'h0000, 1'b0);
         rd_chk(19'h00005, 2, x);
      join
      rd_chk(19'h00007, 2, d);
      // Read slot right after the write slot must see the new burst
      fork
         m.wr(19'h00007, ~d, 16'h0000, 1'b0);
         begin
            m.align(1'b1);
            rd_chk(19'h00007, 2, ~d);
         end
      join
      finish_test;
   end
endmodule
`default_nettype wire
